// [logic/dbl_host.sv]
// host controller driving the double-buffered converter latch pins
// assumes an avalon-mm master on ref_clk and converter pins off chip
//
// Design decisions made here: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ns
`default_nettype none
module dbl_host
    import dbl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    output logic [11:0] dac_data,
    output logic write_strobe_n,
    output logic low_byte_latch_sel_n,
    output logic high_nibble_latch_sel_n,
    output logic output_latch_load_n,
    output logic dac_reset_n
);
    typedef struct packed {
        dbl_state_t state;
        logic [3:0] cnt;
        logic [11:0] data;
        logic wr_n;
        logic lo_n;
        logic hi_n;
        logic ld_n;
        logic twos;
        logic rst_n;
        logic [1:0] kind;
        logic [31:0] rdata;
        logic ack;
    } dbl_host_state_t;

    dbl_host_state_t st_reg, st_next;
    logic [11:0] shadow_word;
    logic sh_low, sh_high, sh_out, sh_clr;

    // ---------------------------------------------
    // select decode per kind
    // ---------------------------------------------
    function automatic logic [2:0] sel_of(input logic [1:0] k);
        // {low, high, load} active-low
        case (k)
            KIND_FULL: sel_of = 3'h0; // see R12
            KIND_LOW: sel_of = 3'h3; // see R10
            KIND_HIGH_LOAD: sel_of = 3'h4; // see R9
            default: sel_of = 3'h6; // see R11
        endcase
    endfunction

    // ---------------------------------------------
    // bus and pin sequencer
    // ---------------------------------------------
    always_comb begin
        logic [2:0] s;
        s = sel_of(st_reg.kind);
        st_next = st_reg;
        st_next.ack = 1'b0;
        case (st_reg.state)
            ST_IDLE: begin
                if (avs_read && !st_reg.ack) begin
                    st_next.ack = 1'b1;
                    case (avs_address)
                        ADDR_CTRL: st_next.rdata = {30'h0, ~st_reg.rst_n,
                            st_reg.twos};
                        ADDR_DATA: st_next.rdata = {20'h0, st_reg.data};
                        ADDR_STAT: st_next.rdata = {19'h0,
                            st_reg.state != ST_IDLE, shadow_word};
                        default: st_next.rdata = UNMAPPED_READ;
                    endcase
                end else if (avs_write && !st_reg.ack) begin
                    if (avs_address == ADDR_CTRL) begin
                        st_next.twos = avs_writedata[CTRL_TWOS];
                        // see R16
                        st_next.rst_n = ~avs_writedata[CTRL_RESET];
                        st_next.ack = 1'b1;
                    end else if (avs_address == ADDR_DATA) begin
                        // see R2 R17
                        st_next.data = {avs_writedata[11] ^ st_reg.twos,
                            avs_writedata[10:0]};
                        st_next.kind =
                            avs_writedata[DATA_KIND_LO +: 2];
                        // selects fall with the data, a cycle before
                        // the strobe, so they are steady under it
                        {st_next.lo_n, st_next.hi_n, st_next.ld_n} =
                            sel_of(avs_writedata[DATA_KIND_LO +: 2]);
                        st_next.state = ST_SETUP;
                        st_next.cnt = SETUP_CYC;
                    end else begin
                        st_next.ack = 1'b1;
                    end
                end
            end
            ST_SETUP: begin
                // selects settle before the strobe falls; see R15
                st_next.lo_n = s[2];
                st_next.hi_n = s[1];
                st_next.ld_n = s[0];
                st_next.cnt = st_reg.cnt - 4'h1;
                if (st_reg.cnt == 4'h1) begin
                    st_next.wr_n = 1'b0; // see R18
                    st_next.state = ST_PULSE;
                    st_next.cnt = PULSE_CYC;
                end
            end
            ST_PULSE: begin
                st_next.cnt = st_reg.cnt - 4'h1;
                if (st_reg.cnt == 4'h1) begin
                    st_next.wr_n = 1'b1; // strobe edge closes; see R15
                    st_next.state = ST_HOLD;
                    st_next.cnt = HOLD_CYC;
                end
            end
            ST_HOLD: begin
                st_next.cnt = st_reg.cnt - 4'h1;
                if (st_reg.cnt == 4'h1) begin
                    st_next.lo_n = 1'b1;
                    st_next.hi_n = 1'b1;
                    st_next.ld_n = 1'b1;
                    st_next.state = ST_IDLE;
                    st_next.ack = 1'b1;
                end
            end
            default: st_next.state = ST_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_reg <= '{state: ST_IDLE, cnt: 4'h0, data: CODE_MID,
                wr_n: 1'b1, lo_n: 1'b1, hi_n: 1'b1, ld_n: 1'b1,
                twos: 1'b0, rst_n: 1'b0, kind: KIND_FULL,
                rdata: 32'h0, ack: 1'b0};
        end else begin
            st_reg <= st_next;
        end
    end

    // shadow updates at the closing strobe edge; see R8
    assign sh_low = st_reg.state == ST_PULSE && st_next.wr_n && !st_reg.lo_n;
    assign sh_high = st_reg.state == ST_PULSE && st_next.wr_n && !st_reg.hi_n;
    assign sh_out = st_reg.state == ST_PULSE && st_next.wr_n && !st_reg.ld_n;
    assign sh_clr = !st_reg.rst_n;

    dbl_shadow u_shadow (
        .ref_clk(ref_clk),
        .reset(reset),
        .clear(sh_clr),
        .load_low(sh_low),
        .load_high(sh_high),
        .load_out(sh_out),
        .word(st_reg.data),
        .out_word(shadow_word)
    );

    assign avs_waitrequest = (avs_read || avs_write) && !st_reg.ack;
    assign avs_readdata = st_reg.rdata;
    assign dac_data = st_reg.data; // see R1
    assign write_strobe_n = st_reg.wr_n;
    assign low_byte_latch_sel_n = st_reg.lo_n;
    assign high_nibble_latch_sel_n = st_reg.hi_n;
    assign output_latch_load_n = st_reg.ld_n;
    assign dac_reset_n = st_reg.rst_n;

    // ---------------------------------------------
    // checks
    // ---------------------------------------------
    property p_strobe_needs_sel;
        @(posedge ref_clk) disable iff (reset)
        !write_strobe_n |-> !(low_byte_latch_sel_n &&
            high_nibble_latch_sel_n && output_latch_load_n);
    endproperty
    a_strobe_needs_sel: assert property (p_strobe_needs_sel) // see R18
        else $error("strobe low with no select");
    property p_sel_stable;
        @(posedge ref_clk) disable iff (reset)
        !write_strobe_n |-> $stable(low_byte_latch_sel_n) &&
            $stable(high_nibble_latch_sel_n) && $stable(dac_data);
    endproperty
    a_sel_stable: assert property (p_sel_stable) // see R15
        else $error("select or data moved under strobe");
    sequence s_pulse;
        $fell(write_strobe_n) ##0 !write_strobe_n [*2];
    endsequence
    property p_pulse_len;
        @(posedge ref_clk) disable iff (reset)
        s_pulse |=> write_strobe_n;
    endproperty
    a_pulse_len: assert property (p_pulse_len) // see R7
        else $error("strobe pulse length wrong");
    property p_out_load;
        @(posedge ref_clk) disable iff (reset)
        (sh_out && dac_reset_n && !high_nibble_latch_sel_n) |=>
            shadow_word[11:8] == $past(dac_data[11:8]);
    endproperty
    a_out_load: assert property (p_out_load) // see R11
        else $error("output mirror not loaded");
    property p_reset_mid;
        @(posedge ref_clk) disable iff (reset)
        !dac_reset_n |=> shadow_word == CODE_MID;
    endproperty
    a_reset_mid: assert property (p_reset_mid) // see R13
        else $error("reset did not give mid code");
    property p_mirror_hold;
        @(posedge ref_clk) disable iff (reset)
        (!sh_out && dac_reset_n) |=> $stable(shadow_word);
    endproperty
    a_mirror_hold: assert property (p_mirror_hold) // see R22
        else $error("mirror moved without load");
    property p_wait_bound;
        @(posedge ref_clk) disable iff (reset)
        $rose(avs_write) |-> ##[0:10] !avs_waitrequest;
    endproperty
    a_wait_bound: assert property (p_wait_bound) // see R21
        else $error("write never answered");
    property p_twos;
        @(posedge ref_clk) disable iff (reset)
        (avs_write && avs_address == ADDR_DATA && st_reg.state == ST_IDLE
            && !st_reg.ack) |=> dac_data[11] ==
            ($past(avs_writedata[11]) ^ st_reg.twos);
    endproperty
    a_twos: assert property (p_twos) // see R2
        else $error("top bit coding wrong");
endmodule
`default_nettype wire

// [logic/dbl_pkg.sv]
// constants shared by the converter latch controller
// assumes the converter pins are driven directly by this block's flops
//
// How it works
// R1: converter reads the word as positive-true binary weights.
// R2: host inverts only the top bit to turn twos code into offset code.
// R3: offset bipolar: 800 is zero, 000 minus and fff plus full scale.
// R4: unipolar: 000 is zero, fff plus full scale, one step per code.
// R5: parts wait in input latches; whole word moves to output latch.
// R6: each of three latches has its own active-low select.
// R7: a latch is open while all its qualifying controls are low.
// R8: a latch holds once any qualifying control goes high.
// R9: strobe and high select low opens only the high-nibble latch.
// R10: strobe and low select low opens only the low-byte latch.
// R11: strobe and load select low moves both input latches out.
// R12: strobe and all selects low make every latch transparent.
// R13: low reset forces output latch to 800 over everything.
// R14: after reset unipolar sits at half scale, bipolar at zero.
// R15: host closes latches with the strobe edge, not the selects.
// R16: reset unused is held high by the host; the host holds it low from reset until a CTRL write clears bit 1.
// R17: calibration uses zero/negative code for offset, full code for gain.
// R18: no latch opens unless the write strobe is low.
// R19: high-nibble latch takes data bits 11 to 8.
// R20: low-byte latch takes data bits 7 to 0.
// R21: synchronous model loads each latch once, in the cycle the strobe closes.
// R22: converter value is exactly the output latch contents.
package dbl_pkg;
    localparam logic [3:0] ADDR_CTRL = 4'h0;
    localparam logic [3:0] ADDR_DATA = 4'h4;
    localparam logic [3:0] ADDR_STAT = 4'h8;
    // ctrl fields
    localparam int CTRL_TWOS = 0;
    localparam int CTRL_RESET = 1;
    localparam int CTRL_MODE_LO = 2;
    // data write fields: bits 11:0 word, 13:12 kind
    localparam int DATA_KIND_LO = 12;
    localparam logic [1:0] KIND_FULL = 2'h0;
    localparam logic [1:0] KIND_LOW = 2'h1;
    localparam logic [1:0] KIND_HIGH_LOAD = 2'h2;
    localparam logic [1:0] KIND_LOAD = 2'h3;
    localparam logic [11:0] CODE_MID = 12'h800;
    localparam logic [11:0] CODE_ZERO = 12'h000;
    localparam logic [11:0] CODE_FULL = 12'hfff;
    localparam logic [31:0] UNMAPPED_READ = 32'h00000000;
    // strobe timing: setup, pulse low, hold cycles (1, 2 and 1 at 50 ns)
    localparam int SETUP_NS = 50;
    localparam int PULSE_NS = 100;
    localparam int HOLD_NS = 50;
    localparam int CLK_NS = 50;
    localparam logic [3:0] SETUP_CYC = 4'((SETUP_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] PULSE_CYC = 4'((PULSE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [3:0] HOLD_CYC = 4'((HOLD_NS + CLK_NS - 1) / CLK_NS);
    typedef enum {ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD} dbl_state_t;
endpackage

// [logic/dbl_shadow.sv]
// mirror of the converter latches as the host has loaded them
// assumes load requests are single-cycle pulses on ref_clk
`timescale 1ns/1ns
`default_nettype none
module dbl_shadow
    import dbl_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic clear,
    input wire logic load_low,
    input wire logic load_high,
    input wire logic load_out,
    input wire logic [11:0] word,
    output logic [11:0] out_word
);
    typedef struct packed {
        logic [7:0] low;
        logic [3:0] high;
        logic [11:0] out;
    } dbl_shadow_state_t;
    dbl_shadow_state_t st_reg, st_next;
    always_comb begin
        st_next = st_reg;
        if (load_low) begin
            st_next.low = word[7:0]; // see R20
        end
        if (load_high) begin
            st_next.high = word[11:8]; // see R19
        end
        if (load_out) begin
            st_next.out = {st_next.high, st_next.low}; // see R5
        end
        if (clear) begin
            st_next.out = CODE_MID; // see R13
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_reg <= '{low: 8'h00, high: 4'h8, out: CODE_MID};
        end else begin
            st_reg <= st_next;
        end
    end
    assign out_word = st_reg.out;
endmodule
`default_nettype wire

// [verification/dbl_dev_model.sv]
// behavioural model of the converter's latch input logic
// assumes its pins come straight from the host controller
`timescale 1ns/1ns
`default_nettype none
module dbl_dev_model (
    input wire logic [11:0] dac_data,
    input wire logic write_strobe_n,
    input wire logic low_byte_latch_sel_n,
    input wire logic high_nibble_latch_sel_n,
    input wire logic output_latch_load_n,
    input wire logic dac_reset_n,
    output logic [11:0] dac_value
);
    logic [7:0] low_reg;
    logic [3:0] high_reg;
    // input latches settle first so transparent mode passes straight on
    // closed latches simply keep their value
    always @* begin
        if (!write_strobe_n && !low_byte_latch_sel_n) begin
            low_reg = dac_data[7:0];
        end
        if (!write_strobe_n && !high_nibble_latch_sel_n) begin
            high_reg = dac_data[11:8];
        end
        // value kept as plain positive-true binary
        if (!dac_reset_n) begin
            dac_value = 12'h800;
        end else if (!write_strobe_n && !output_latch_load_n) begin
            dac_value = {high_reg, low_reg};
        end
    end
endmodule
`default_nettype wire

// [verification/dac_double_buffered_input_latch_tb.sv]
// self-checking bench for the converter latch host controller
// assumes one 20 MHz clock and the behavioural device model
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin fails++; \
    $display("[ERR] %0t got %h want %h", $time, a, b); end end
module dac_double_buffered_input_latch_tb;
    import dbl_pkg::*;
    logic ref_clk = 1'b0;
    logic reset = 1'b1;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [11:0] dac_data, dac_value;
    logic write_strobe_n, low_byte_latch_sel_n, high_nibble_latch_sel_n;
    logic output_latch_load_n, dac_reset_n;
    logic [2:0] sel_prev;
    logic [31:0] rd;
    int fails = 0;
    int n_compared = 0;
    always #25 ref_clk = ~ref_clk;
    dbl_host dut_u (.ref_clk(ref_clk), .reset(reset),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .dac_data(dac_data), .write_strobe_n(write_strobe_n),
        .low_byte_latch_sel_n(low_byte_latch_sel_n),
        .high_nibble_latch_sel_n(high_nibble_latch_sel_n),
        .output_latch_load_n(output_latch_load_n), .dac_reset_n(dac_reset_n));
    dbl_dev_model dev_u (.dac_data(dac_data), .write_strobe_n(write_strobe_n),
        .low_byte_latch_sel_n(low_byte_latch_sel_n),
        .high_nibble_latch_sel_n(high_nibble_latch_sel_n),
        .output_latch_load_n(output_latch_load_n),
        .dac_reset_n(dac_reset_n), .dac_value(dac_value));
    // selects must stay put while the strobe is low: strobe closes latches
    always @(posedge ref_clk) begin
        if (!reset && write_strobe_n === 1'b0) begin
            `CHK({low_byte_latch_sel_n, high_nibble_latch_sel_n,
                output_latch_load_n}, sel_prev)
        end
        sel_prev <= {low_byte_latch_sel_n, high_nibble_latch_sel_n,
            output_latch_load_n};
    end
    task automatic report_and_stop();
        $display("compared %0d fails %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // one avalon transfer; answer is taken where waitrequest is low
    task automatic bus(input logic wr, input logic [3:0] a,
        input logic [31:0] d);
        int i;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        for (i = 0; i < 40; i++) begin
            @(posedge ref_clk);
            if (avs_waitrequest === 1'b0) break;
        end
        if (i == 40) begin
            fails++;
            $display("[ERR] %0t bus timeout", $time);
        end
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask
    task automatic put(input logic [1:0] k, input logic [11:0] w);
        bus(1'b1, ADDR_DATA, {18'h0, k, w});
    endtask
    task automatic t_reset_state();
        bus(1'b0, ADDR_CTRL, 32'h0);
        `CHK(rd[CTRL_RESET], 1'b1)
        `CHK(dac_value, CODE_MID)
        put(KIND_FULL, 12'h123);
        `CHK(dac_value, CODE_MID)
        bus(1'b0, 4'hc, 32'h0);
        `CHK(rd, UNMAPPED_READ)
        bus(1'b1, 4'hc, 32'h3);
        bus(1'b1, ADDR_CTRL, 32'h0);
        `CHK(dac_reset_n, 1'b1)
    endtask
    task automatic t_split_load();
        put(KIND_FULL, 12'habc);
        `CHK(dac_value, 12'habc)
        put(KIND_LOW, 12'h05a);
        `CHK(dac_value, 12'habc)
        put(KIND_HIGH_LOAD, 12'h3ff);
        `CHK(dac_value, 12'h35a)
        put(KIND_LOW, 12'h0c3);
        `CHK(dac_value, 12'h35a)
        put(KIND_LOAD, 12'h000);
        `CHK(dac_value, 12'h3c3)
        bus(1'b0, ADDR_STAT, 32'h0);
        `CHK(rd[11:0], 12'h3c3)
        `CHK(rd[12], 1'b0)
        bus(1'b0, ADDR_DATA, 32'h0);
        `CHK(rd[11:0], 12'h000)
    endtask
    task automatic t_codes();
        logic [11:0] c [4];
        c = '{CODE_ZERO, CODE_MID, 12'h7ff, CODE_FULL};
        foreach (c[i]) begin
            put(KIND_FULL, c[i]);
            `CHK(dac_value, c[i])
        end
        bus(1'b1, ADDR_CTRL, 32'h1);
        bus(1'b0, ADDR_CTRL, 32'h0);
        `CHK(rd[1:0], 2'h1)
        put(KIND_FULL, 12'h123);
        `CHK(dac_value, 12'h923)
        put(KIND_FULL, 12'h800);
        `CHK(dac_value, 12'h000)
        bus(1'b1, ADDR_CTRL, 32'h2);
        `CHK(dac_value, CODE_MID)
        bus(1'b1, ADDR_CTRL, 32'h0);
        `CHK(dac_value, CODE_MID)
    endtask
    initial begin
        repeat (10) @(posedge ref_clk);
        reset <= 1'b0;
        t_reset_state();
        t_split_load();
        t_codes();
        report_and_stop();
    end
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        report_and_stop();
    end
endmodule
`default_nettype wire
